/* File: hw/ast_pkg.sv */
// types shared by the serial transceiver
package ast_pkg;
	typedef struct packed {
		logic       sps;
		logic [1:0] wlen;
		logic       fifo_enable_bit;
		logic       stp2;
		logic       eps;
		logic       pen;
		logic       brk;
	} ast_lcr_t;
	typedef struct packed {
		logic [15:0] div_int;
		logic [5:0]  div_frac;
		ast_lcr_t    lcr;
	} ast_cfg_t;
	typedef struct packed {
		logic       ovr;
		logic       brk;
		logic       par;
		logic       frm;
		logic [7:0] data;
	} ast_rxent_t;
	typedef enum logic [2:0] {
		AST_IDLE  = 3'b000,
		AST_START = 3'b001,
		AST_DATA  = 3'b010,
		AST_PAR   = 3'b011,
		AST_STOP  = 3'b100
	} ast_state_t;
endpackage

/* File: hw/ast_regs.svh */
// register offsets, field positions, reset values and timing counts
// Functional notes
// - separate tx and rx direction enables, both set after reset
// - clearing the global enable lets the current character finish
// - frame is low start, data lsb first, optional parity, stop bits
// - data length of five, six, seven or eight bits
// - parity may be even, odd, stick or none
// - one or two stop bits appended
// - divisor is 16 integer bits plus 6 fraction bits, own registers
// - oversample tick at sixteen times baud; tx bit lasts sixteen ticks
// - divisors and line control latched together on line control write
// - sixteen entry tx and rx fifos; rx entries carry four status bits
// - fifo depth programmable, single entry mode included
// - enabled transmitter sends back to back until fifo empty
// - busy from fifo non-empty until last stop bit sent
// - falling receive line starts count; sample on eighth tick
// - line high at eighth tick is a false start, flagged and dropped
// - data bits sampled every sixteenth tick after valid start
// - received parity checked against mode, mismatch flagged
// - low stop sample flags a framing error
// - overrun, parity, framing, break detected and stored with char
// - after reset fifos are single entry until fifo enable set
// - data read gives 8 data plus 4 flags; write pushes 8 bits
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
// ==================================
// byte offsets
`define AST_OFS_DATA  12'h000
`define AST_OFS_RXERR 12'h004
`define AST_OFS_FLAG  12'h018
`define AST_OFS_DIVI  12'h024
`define AST_OFS_DIVF  12'h028
`define AST_OFS_LCR   12'h02c
`define AST_OFS_CTL   12'h030
// ==================================
// control and flag bit positions
`define AST_CTL_EN    0
`define AST_CTL_TXE   8
`define AST_CTL_RXE   9
`define AST_FLAG_BUSY 3
`define AST_FLAG_RXFE 4
`define AST_FLAG_TXFF 5
`define AST_FLAG_RXFF 6
`define AST_FLAG_TXFE 7
// ==================================
// reset values
`define AST_EN_RST    1'b0
`define AST_DIR_RST   1'b1
`define AST_DIVI_RST  16'h0000
`define AST_DIVF_RST  6'h00
`define AST_LCR_RST   8'h00
// ==================================
// oversample tick indices
`define AST_START_TICK 4'h7
`define AST_BIT_TICK   4'hf
`endif

/* File: hw/ast_top.sv */
// serial transceiver with fifos and an avalon-mm register slave
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_top #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// avalon-mm slave
	input  wire logic [11:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// serial line
	input  wire logic        i_rx_serial,
	output logic             o_tx_serial
);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEP = CW'(DEPTH);

	// ==================================
	// bus slave
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        req;
	logic        wr;
	logic        rd;
	logic [11:0] ofs;
	assign req = i_avs_read | i_avs_write;
	assign wr  = i_avs_write & ack_reg;
	assign rd  = i_avs_read & ack_reg;
	assign ofs = {i_avs_address[11:2], 2'b00};
	// one wait cycle so read data come from a flop
	assign o_avs_waitrequest = req & ~ack_reg;
	assign o_avs_readdata    = rdata_reg;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// ==================================
	// control registers
	logic              en_reg;
	logic              txe_reg;
	logic              rxe_reg;
	logic [15:0]       divi_reg;
	logic [5:0]        divf_reg;
	ast_pkg::ast_lcr_t lcr_reg;
	ast_pkg::ast_cfg_t cfg_reg;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			en_reg   <= `AST_EN_RST;
			txe_reg  <= `AST_DIR_RST;
			rxe_reg  <= `AST_DIR_RST;
			divi_reg <= `AST_DIVI_RST;
			divf_reg <= `AST_DIVF_RST;
			lcr_reg  <= `AST_LCR_RST;
			cfg_reg  <= {`AST_DIVI_RST, `AST_DIVF_RST, `AST_LCR_RST};
		end else if (wr) begin
			if (ofs == `AST_OFS_CTL) begin
				en_reg  <= i_avs_writedata[`AST_CTL_EN];
				txe_reg <= i_avs_writedata[`AST_CTL_TXE];
				rxe_reg <= i_avs_writedata[`AST_CTL_RXE];
			end
			if (ofs == `AST_OFS_DIVI)
				divi_reg <= i_avs_writedata[15:0];
			if (ofs == `AST_OFS_DIVF)
				divf_reg <= i_avs_writedata[5:0];
			if (ofs == `AST_OFS_LCR) begin
				lcr_reg <= i_avs_writedata[7:0];
				cfg_reg <= {divi_reg, divf_reg, i_avs_writedata[7:0]};
			end
		end
	end

	// ==================================
	// parity of a character under the latched format
	function automatic logic par_of(input logic [7:0] d, input ast_pkg::ast_lcr_t l);
		logic [7:0] m;
		m = 8'hff >> (2'd3 - l.wlen);
		if (l.sps)
			par_of = ~l.eps;
		else
			par_of = (^(d & m)) ^ ~l.eps;
	endfunction

	logic [2:0] last_bit;
	logic [CW-1:0] lim;
	assign last_bit = {1'b0, cfg_reg.lcr.wlen} + 3'h4;
	assign lim      = cfg_reg.lcr.fifo_enable_bit ? DEP : CW'(1);

	// ==================================
	// oversample tick generator
	logic [15:0] bcnt_reg;
	logic [5:0]  bacc_reg;
	logic        tick_reg;
	logic [6:0]  fsum;
	assign fsum = {1'b0, bacc_reg} + {1'b0, cfg_reg.div_frac};

	// fraction carry stretches one period by a clock to reach the mean rate
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bcnt_reg <= 16'h0000;
			bacc_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else if (cfg_reg.div_int == 16'h0000) begin
			bcnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (bcnt_reg == 16'h0000) begin
			tick_reg <= 1'b1;
			bacc_reg <= fsum[5:0];
			bcnt_reg <= cfg_reg.div_int - 16'h0001 + {15'h0000, fsum[6]};
		end else begin
			tick_reg <= 1'b0;
			bcnt_reg <= bcnt_reg - 16'h0001;
		end
	end

	// ==================================
	// transmit fifo
	logic [7:0]    tx_mem [DEPTH];
	logic [AW-1:0] tx_wp;
	logic [AW-1:0] tx_rp;
	logic [CW-1:0] tx_cnt;
	logic          tx_empty;
	logic          tx_full;
	logic          tx_push;
	logic          tx_pop;
	ast_pkg::ast_state_t tx_st;
	assign tx_empty = tx_cnt == CW'(0);
	assign tx_full  = tx_cnt >= lim;
	// writes to a full fifo are dropped
	assign tx_push  = wr && ofs == `AST_OFS_DATA && !tx_full;
	assign tx_pop   = tx_st == ast_pkg::AST_IDLE && en_reg && txe_reg && !tx_empty;

	always_ff @(posedge i_clk) begin
		if (tx_push)
			tx_mem[tx_wp] <= i_avs_writedata[7:0];
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_wp  <= '0;
			tx_rp  <= '0;
			tx_cnt <= '0;
		end else begin
			if (tx_push)
				tx_wp <= tx_wp + AW'(1);
			if (tx_pop)
				tx_rp <= tx_rp + AW'(1);
			tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
		end
	end

	// ==================================
	// transmitter
	logic [3:0] tx_tcnt;
	logic [2:0] tx_bit;
	logic [7:0] tx_sh;
	logic       tx_par;
	logic       tx_stop1;
	logic       tx_line_reg;
	logic       txo_reg;
	logic       busy;
	assign busy = !tx_empty || tx_st != ast_pkg::AST_IDLE;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_st       <= ast_pkg::AST_IDLE;
			tx_tcnt     <= 4'h0;
			tx_bit      <= 3'h0;
			tx_sh       <= 8'h00;
			tx_par      <= 1'b0;
			tx_stop1    <= 1'b0;
			tx_line_reg <= 1'b1;
		end else begin
			unique case (tx_st)
				ast_pkg::AST_IDLE: begin
					tx_line_reg <= 1'b1;
					tx_tcnt     <= 4'h0;
					// new frame only while enabled; a running one always ends
					if (tx_pop) begin
						tx_st       <= ast_pkg::AST_START;
						tx_sh       <= tx_mem[tx_rp];
						tx_par      <= par_of(tx_mem[tx_rp], cfg_reg.lcr);
						tx_line_reg <= 1'b0;
					end
				end
				ast_pkg::AST_START, ast_pkg::AST_DATA, ast_pkg::AST_PAR,
				ast_pkg::AST_STOP: begin
					if (tick_reg) begin
						tx_tcnt <= tx_tcnt + 4'h1;
					end
					if (tick_reg && tx_tcnt == `AST_BIT_TICK) begin
						unique case (tx_st)
							ast_pkg::AST_START: begin
								tx_st       <= ast_pkg::AST_DATA;
								tx_bit      <= 3'h0;
								tx_line_reg <= tx_sh[0];
							end
							ast_pkg::AST_DATA: begin
								if (tx_bit == last_bit) begin
									tx_st       <= cfg_reg.lcr.pen ? ast_pkg::AST_PAR
										: ast_pkg::AST_STOP;
									tx_line_reg <= cfg_reg.lcr.pen ? tx_par : 1'b1;
									tx_stop1    <= 1'b0;
								end else begin
									tx_bit      <= tx_bit + 3'h1;
									tx_sh       <= tx_sh >> 1;
									tx_line_reg <= tx_sh[1];
								end
							end
							ast_pkg::AST_PAR: begin
								tx_st       <= ast_pkg::AST_STOP;
								tx_line_reg <= 1'b1;
								tx_stop1    <= 1'b0;
							end
							default: begin
								if (cfg_reg.lcr.stp2 && !tx_stop1)
									tx_stop1 <= 1'b1;
								else
									tx_st <= ast_pkg::AST_IDLE;
							end
						endcase
					end
				end
				default: tx_st <= ast_pkg::AST_IDLE;
			endcase
		end
	end

	// break forces the line low whatever the shifter holds
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			txo_reg <= 1'b1;
		else
			txo_reg <= tx_line_reg & ~cfg_reg.lcr.brk;
	end
	assign o_tx_serial = txo_reg;

	// ==================================
	// receive line synchroniser
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_filt;
	logic rx_prev;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_s3   <= 1'b1;
			rx_filt <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1   <= i_rx_serial;
			rx_s2   <= rx_s1;
			rx_s3   <= rx_s2;
			rx_filt <= (rx_s2 == rx_s3) ? rx_s3 : rx_filt;
			rx_prev <= rx_filt;
		end
	end

	// ==================================
	// receiver
	ast_pkg::ast_state_t rx_st;
	ast_pkg::ast_rxent_t rx_ent_reg;
	logic [3:0] rx_tcnt;
	logic [2:0] rx_bit;
	logic [7:0] rx_sh;
	logic       rx_perr;
	logic       rx_zero;
	logic       rx_push_reg;
	logic       start_set;
	logic       ovr_pend;
	logic       rx_fall;
	logic       rx_at;
	// a fall only counts after the line was seen high
	assign rx_fall = rx_prev && !rx_filt;
	assign rx_at   = tick_reg && rx_tcnt == `AST_BIT_TICK;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_st       <= ast_pkg::AST_IDLE;
			rx_tcnt     <= 4'h0;
			rx_bit      <= 3'h0;
			rx_sh       <= 8'h00;
			rx_perr     <= 1'b0;
			rx_zero     <= 1'b0;
			rx_push_reg <= 1'b0;
			rx_ent_reg  <= '0;
			start_set   <= 1'b0;
		end else begin
			rx_push_reg <= 1'b0;
			start_set   <= 1'b0;
			if (tick_reg)
				rx_tcnt <= rx_tcnt + 4'h1;
			unique case (rx_st)
				ast_pkg::AST_IDLE: begin
					if (en_reg && rxe_reg && rx_fall) begin
						rx_st   <= ast_pkg::AST_START;
						rx_tcnt <= 4'h0;
					end
				end
				ast_pkg::AST_START: begin
					if (tick_reg && rx_tcnt == `AST_START_TICK) begin
						rx_tcnt <= 4'h0;
						if (rx_filt) begin
							rx_st     <= ast_pkg::AST_IDLE;
							start_set <= 1'b1;
						end else begin
							rx_st   <= ast_pkg::AST_DATA;
							rx_bit  <= 3'h0;
							rx_sh   <= 8'h00;
							rx_perr <= 1'b0;
							rx_zero <= 1'b1;
						end
					end
				end
				ast_pkg::AST_DATA: begin
					if (rx_at) begin
						rx_sh[rx_bit] <= rx_filt;
						rx_zero       <= rx_zero & ~rx_filt;
						if (rx_bit == last_bit)
							rx_st <= cfg_reg.lcr.pen ? ast_pkg::AST_PAR : ast_pkg::AST_STOP;
						else
							rx_bit <= rx_bit + 3'h1;
					end
				end
				ast_pkg::AST_PAR: begin
					if (rx_at) begin
						rx_perr <= rx_filt != par_of(rx_sh, cfg_reg.lcr);
						rx_zero <= rx_zero & ~rx_filt;
						rx_st   <= ast_pkg::AST_STOP;
					end
				end
				ast_pkg::AST_STOP: begin
					if (rx_at) begin
						rx_st           <= ast_pkg::AST_IDLE;
						rx_push_reg     <= 1'b1;
						rx_ent_reg.data <= rx_sh;
						rx_ent_reg.frm  <= !rx_filt;
						rx_ent_reg.par  <= rx_perr;
						rx_ent_reg.brk  <= rx_zero && !rx_filt;
						rx_ent_reg.ovr  <= 1'b0;
					end
				end
				default: rx_st <= ast_pkg::AST_IDLE;
			endcase
		end
	end

	// ==================================
	// receive fifo
	ast_pkg::ast_rxent_t rx_mem [DEPTH];
	logic [AW-1:0] rx_wp;
	logic [AW-1:0] rx_rp;
	logic [CW-1:0] rx_cnt;
	logic          rx_empty;
	logic          rx_full;
	logic          rx_wr;
	logic          rx_pop;
	logic          rx_ovf;
	assign rx_empty = rx_cnt == CW'(0);
	assign rx_full  = rx_cnt >= lim;
	assign rx_wr    = rx_push_reg && !rx_full;
	assign rx_ovf   = rx_push_reg && rx_full;
	assign rx_pop   = rd && ofs == `AST_OFS_DATA && !rx_empty;

	// an overrun tags the next character that fits
	always_ff @(posedge i_clk) begin
		if (rx_wr)
			rx_mem[rx_wp] <= {ovr_pend, rx_ent_reg[10:0]};
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_wp    <= '0;
			rx_rp    <= '0;
			rx_cnt   <= '0;
			ovr_pend <= 1'b0;
		end else begin
			if (rx_wr)
				rx_wp <= rx_wp + AW'(1);
			if (rx_pop)
				rx_rp <= rx_rp + AW'(1);
			rx_cnt <= rx_cnt + CW'(rx_wr) - CW'(rx_pop);
			if (rx_ovf)
				ovr_pend <= 1'b1;
			else if (rx_wr)
				ovr_pend <= 1'b0;
		end
	end

	// ==================================
	// sticky error status, set wins over clear
	logic [4:0] err_reg;
	logic [4:0] err_set;
	logic       err_clr;
	assign err_set = {start_set, rx_ovf, rx_push_reg & rx_ent_reg.brk,
		rx_push_reg & rx_ent_reg.par, rx_push_reg & rx_ent_reg.frm};
	assign err_clr = wr && ofs == `AST_OFS_RXERR;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			err_reg <= 5'h00;
		else
			err_reg <= err_set | (err_reg & {5{~err_clr}});
	end

	// ==================================
	// read mux
	always_comb begin
		case (ofs)
			`AST_OFS_DATA:  rdata_next = rx_empty ? 32'h0 : {20'h0, rx_mem[rx_rp]};
			`AST_OFS_RXERR: rdata_next = {27'h0, err_reg};
			`AST_OFS_FLAG:  rdata_next = {24'h0, tx_empty, rx_full, tx_full, rx_empty,
				busy, 3'h0};
			`AST_OFS_DIVI:  rdata_next = {16'h0, divi_reg};
			`AST_OFS_DIVF:  rdata_next = {26'h0, divf_reg};
			`AST_OFS_LCR:   rdata_next = {24'h0, lcr_reg};
			`AST_OFS_CTL:   rdata_next = {22'h0, rxe_reg, txe_reg, 7'h0, en_reg};
			default:        rdata_next = 32'h0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			rdata_reg <= 32'h0;
		else if (req && !ack_reg)
			rdata_reg <= rdata_next;
	end

	// ==================================
	// checks
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_start_low: assert property (tx_st == ast_pkg::AST_START |-> !tx_line_reg)
		else $error("start bit not low");
	a_idle_high: assert property (tx_st == ast_pkg::AST_IDLE |-> tx_line_reg)
		else $error("idle line not high");
	a_busy_push: assert property (tx_push |=> busy [*2])
		else $error("busy missing after push");
	a_cfg_latch: assert property (wr && ofs == `AST_OFS_LCR |=>
		cfg_reg.div_int == $past(divi_reg) && cfg_reg.div_frac == $past(divf_reg))
		else $error("divisor not latched");
	a_cfg_hold: assert property (!(wr && ofs == `AST_OFS_LCR) |=> $stable(cfg_reg))
		else $error("config changed without line control write");
	a_tx_bitlen: assert property (tx_st == ast_pkg::AST_START && tick_reg &&
		tx_tcnt == `AST_BIT_TICK |=> tx_st == ast_pkg::AST_DATA)
		else $error("start bit length wrong");
	a_rx_begin: assert property (rx_st == ast_pkg::AST_IDLE && en_reg && rxe_reg &&
		rx_fall |=> rx_st == ast_pkg::AST_START && rx_tcnt == 4'h0)
		else $error("receiver missed start edge");
	a_false_start: assert property (rx_st == ast_pkg::AST_START && tick_reg &&
		rx_tcnt == `AST_START_TICK && rx_filt |=> rx_st == ast_pkg::AST_IDLE ##1 err_reg[4])
		else $error("false start not flagged");
	a_frame_err: assert property (rx_st == ast_pkg::AST_STOP && rx_at && !rx_filt
		|=> rx_push_reg && rx_ent_reg.frm)
		else $error("framing error not flagged");
	a_fifo_single: assert property (!cfg_reg.lcr.fifo_enable_bit |-> tx_cnt <= CW'(1) &&
		rx_cnt <= CW'(1))
		else $error("fifo deeper than one when disabled");
	a_tx_gate: assert property (tx_st == ast_pkg::AST_IDLE && !txe_reg
		|=> tx_st == ast_pkg::AST_IDLE)
		else $error("transmit started while disabled");
	a_rx_gate: assert property (rx_st == ast_pkg::AST_IDLE && !rxe_reg
		|=> rx_st == ast_pkg::AST_IDLE)
		else $error("receive started while disabled");

	c_tx_frame: cover property (tx_st == ast_pkg::AST_STOP ##1 tx_st == ast_pkg::AST_IDLE);
	c_rx_push: cover property (rx_wr);
	c_false_start: cover property (start_set);
	c_overrun: cover property (rx_ovf);
endmodule

/* File: testbench/ast_peer.sv */
// remote serial peer: captures frames from the transceiver and sends frames to it
`timescale 1ns/1ns
module ast_peer #(
	parameter int BIT = 32
) (
	// clock
	input  wire logic       i_clk,
	// serial lines and expected frame shape
	input  wire logic       i_line,
	input  wire logic [3:0] i_nbits,
	input  wire logic       i_stop2,
	output logic            o_line,
	// captured frame
	output logic            o_valid,
	output logic [8:0]      o_word,
	output logic            o_stop_ok
);
	logic [8:0] w;
	logic       ok;

	initial begin
		o_line = 1'b1;
		o_valid = 1'b0;
		o_word = 9'h000;
		o_stop_ok = 1'b0;
	end

	// ==================================
	// capture, sampled at mid-bit
	initial begin
		forever begin
			@(posedge i_clk);
			if (i_line === 1'b0) begin
				repeat (BIT / 2) @(posedge i_clk);
				if (i_line === 1'b0) begin
					w = 9'h000;
					for (int i = 0; i < i_nbits; i++) begin
						repeat (BIT) @(posedge i_clk);
						w[i] = i_line;
					end
					repeat (BIT) @(posedge i_clk);
					ok = i_line;
					if (i_stop2) begin
						repeat (BIT) @(posedge i_clk);
						ok = ok & i_line;
					end
					o_word <= w;
					o_stop_ok <= ok;
					o_valid <= 1'b1;
					@(posedge i_clk);
					o_valid <= 1'b0;
				end
			end
		end
	end

	// ==================================
	// sending; line idles high, called just after a clock edge
	task automatic send_frame(input logic [8:0] bits, input int n, input logic stop_v);
		o_line <= 1'b0;
		repeat (BIT) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_line <= bits[i];
			repeat (BIT) @(posedge i_clk);
		end
		o_line <= stop_v;
		repeat (BIT) @(posedge i_clk);
		o_line <= 1'b1;
		repeat (BIT) @(posedge i_clk);
	endtask

	// short low pulse that never reaches mid start bit
	task automatic glitch(input int len);
		o_line <= 1'b0;
		repeat (len) @(posedge i_clk);
		o_line <= 1'b1;
		repeat (BIT * 2) @(posedge i_clk);
	endtask
endmodule

/* File: testbench/ast_top_tb_top.sv */
// self-checking bench for the serial transceiver
`timescale 1ns/1ns
`include "ast_regs.svh"
module ast_top_tb_top;
	logic                i_clk;
	logic                i_rst_b;
	logic [11:0]         i_avs_address;
	logic                i_avs_read;
	logic                i_avs_write;
	logic [31:0]         i_avs_writedata;
	logic [31:0]         o_avs_readdata;
	logic                o_avs_waitrequest;
	logic                rx_line;
	logic                tx_line;
	logic [3:0]          nbits;
	logic                stop2;
	logic                pv;
	logic [8:0]          pword;
	logic                pok;
	logic [31:0]         exp_q[$];
	logic [31:0]         msk_q[$];
	logic [9:0]          line_q[$];
	logic [31:0]         q;
	logic [31:0]         seed;
	logic [7:0]          d;
	ast_pkg::ast_lcr_t   l;
	int                  mismatches;
	int                  compares;
	int                  cycles;

	ast_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_rx_serial(rx_line), .o_tx_serial(tx_line));
	ast_peer #(.BIT(32)) peer (.i_clk(i_clk), .i_line(tx_line), .i_nbits(nbits),
		.i_stop2(stop2), .o_line(rx_line), .o_valid(pv), .o_word(pword), .o_stop_ok(pok));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// ==================================
	// comparison, report and watchers
	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		compares++;
		if (seen !== expv) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// read data taken at the edge where waitrequest is seen low
	always @(posedge i_clk) begin
		if (i_avs_read && o_avs_waitrequest === 1'b0 && exp_q.size() > 0)
			check(o_avs_readdata & msk_q.pop_front(), exp_q.pop_front());
		if (pv === 1'b1)
			check({22'h0, pok, pword}, {22'h0, line_q.pop_front()});
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			test_done();
		end
	end

	// ==================================
	// avalon-mm master
	task automatic bus(input logic rd_n, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= wd;
		if (rd_n) begin
			exp_q.push_back(e & m);
			msk_q.push_back(m);
			i_avs_read <= 1'b1;
		end else begin
			i_avs_write <= 1'b1;
		end
		do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		bus(1'b0, a, wd, 32'h0, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b1, a, 32'h0, e, m);
	endtask

	task automatic wait_flag(input int b, input logic v);
		int n;
		n = 0;
		do begin
			rd(`AST_OFS_FLAG, 32'h0, 32'h0);
			n++;
		end while (q[b] !== v && n < 3000);
	endtask

	// software disables, loads line control, then writes the given control word
	task automatic cfg(input ast_pkg::ast_lcr_t lc, input logic [31:0] ctl);
		wr(`AST_OFS_CTL, 32'h300);
		wr(`AST_OFS_LCR, {24'h0, lc});
		wr(`AST_OFS_CTL, ctl);
		nbits <= {2'b00, lc.wlen} + 4'h5 + {3'b000, lc.pen};
		stop2 <= lc.stp2;
	endtask

	function automatic logic par_bit(input ast_pkg::ast_lcr_t lc, input logic [7:0] v);
		if (lc.sps)
			return ~lc.eps;
		return lc.eps ? ^v : ~^v;
	endfunction

	task automatic tx_one(input ast_pkg::ast_lcr_t lc, input logic [7:0] v);
		logic [8:0] e;
		int         wl;
		wl = 5 + int'(lc.wlen);
		e = {1'b0, v & (8'hff >> (8 - wl))};
		if (lc.pen)
			e[wl] = par_bit(lc, e[7:0]);
		line_q.push_back({1'b1, e});
		wr(`AST_OFS_DATA, {24'h0, v});
		rd(`AST_OFS_FLAG, 32'h08, 32'h08);
		wait_flag(3, 1'b0);
		rd(`AST_OFS_FLAG, 32'h90, 32'hff);
	endtask

	// parity is even, as configured for the receive tests
	task automatic rx_case(input logic [7:0] v, input logic flip, input logic stop_v,
		input logic [3:0] err);
		peer.send_frame({^v ^ flip, v}, 9, stop_v);
		wait_flag(4, 1'b0);
		rd(`AST_OFS_DATA, {20'h0, err, v}, 32'hfff);
	endtask

	// ==================================
	// main sequence
	initial begin
		i_rst_b = 1'b0;
		i_avs_address = 12'h000;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		nbits = 4'h8;
		stop2 = 1'b0;
		mismatches = 0;
		compares = 0;
		cycles = 0;
		seed = $urandom(32'hc9b0);
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(`AST_OFS_CTL, 32'h300, 32'hffffffff);
		rd(`AST_OFS_FLAG, 32'h90, 32'hffffffff);
		wr(12'h100, 32'hffffffff);
		rd(12'h100, 32'h0, 32'hffffffff);
		wr(`AST_OFS_DIVI, 32'hffffffff);
		wr(`AST_OFS_DIVF, 32'hffffffff);
		rd(`AST_OFS_DIVI, 32'hffff, 32'hffffffff);
		rd(`AST_OFS_DIVF, 32'h3f, 32'hffffffff);
		wr(`AST_OFS_DIVF, 32'h0);
		wr(`AST_OFS_DIVI, 32'h2);
		// every length, parity mode and stop count
		for (int m = 0; m < 16; m++) begin
			l = '0;
			l.wlen = m[1:0];
			l.pen = |m[3:2];
			l.eps = (m[3:2] == 2'b01) | (m[3:2] == 2'b11 & m[0]);
			l.sps = &m[3:2];
			l.stp2 = m[0];
			cfg(l, 32'h301);
			tx_one(l, 8'($urandom));
		end
		// fifo filled while disabled, one character sent under a brief enable, the rest then drained back to back
		l = '0;
		l.wlen = 2'b11;
		l.fifo_enable_bit = 1'b1;
		cfg(l, 32'h300);
		for (int k = 0; k < 17; k++) begin
			d = 8'($urandom);
			if (k < 16)
				line_q.push_back({2'b10, d});
			wr(`AST_OFS_DATA, {24'h0, d});
		end
		rd(`AST_OFS_FLAG, 32'h28, 32'ha8);
		wr(`AST_OFS_CTL, 32'h301);
		wr(`AST_OFS_CTL, 32'h300);
		wait (pv === 1'b1);
		@(posedge i_clk);
		rd(`AST_OFS_FLAG, 32'h08, 32'h88);
		wr(`AST_OFS_CTL, 32'h301);
		wait_flag(3, 1'b0);
		check(32'(line_q.size()), 32'h0);
		// receive: false start, good, parity, framing, break
		l = '0;
		l.wlen = 2'b11;
		l.pen = 1'b1;
		l.eps = 1'b1;
		cfg(l, 32'h301);
		wr(`AST_OFS_RXERR, 32'h0);
		peer.glitch(6);
		rd(`AST_OFS_RXERR, 32'h10, 32'hffffffff);
		rd(`AST_OFS_FLAG, 32'h10, 32'h10);
		rx_case(8'($urandom), 1'b0, 1'b1, 4'h0);
		rx_case(8'($urandom), 1'b1, 1'b1, 4'h2);
		rx_case(8'h5a, 1'b0, 1'b0, 4'h1);
		rx_case(8'h00, 1'b0, 1'b0, 4'h5);
		rd(`AST_OFS_RXERR, 32'h17, 32'hffffffff);
		// single entry holding register overrun
		d = 8'($urandom);
		peer.send_frame({^d, d}, 9, 1'b1);
		peer.send_frame(9'h0c3, 9, 1'b1);
		rd(`AST_OFS_RXERR, 32'h08, 32'h08);
		rd(`AST_OFS_DATA, {24'h0, d}, 32'hfff);
		rx_case(8'h3c, 1'b0, 1'b1, 4'h8);
		// both directions off: character held, incoming frame ignored
		cfg(l, 32'h001);
		d = 8'($urandom);
		line_q.push_back({1'b1, ^d, d});
		wr(`AST_OFS_DATA, {24'h0, d});
		peer.send_frame({^d, d}, 9, 1'b1);
		rd(`AST_OFS_FLAG, 32'h18, 32'h98);
		wr(`AST_OFS_CTL, 32'h301);
		wait_flag(3, 1'b0);
		check(32'(line_q.size()), 32'h0);
		// line break: peer sees an all-low character with a low stop
		l.brk = 1'b1;
		line_q.push_back(10'h000);
		cfg(l, 32'h300);
		wait (pv === 1'b1);
		l.brk = 1'b0;
		cfg(l, 32'h300);
		test_done();
	end
endmodule
